// >>> dv/acbd_host_model.sv
// Host side of the serial link: select, shift clock and data in.
// Assumes the bench core clock; pins change just after its falling edge.
module acbd_host_model (
    input  wire logic core_clk,
    output logic      selectLowN,
    output logic      serialClk,
    output logic      serialIn,
    input  wire logic doutPin,
    input  wire logic strobePin,
    input  wire logic trackInput
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle: deselected, shift clock parked low between frames
    initial begin
        selectLowN = 1'b1;
        serialClk  = 1'b0;
        serialIn   = 1'b0;
    end

    // Select level change
    task automatic set_select(input logic lowN);
        @(negedge core_clk);
        selectLowN = lowN;
    endtask

    // Shift pat[k] on rise k, record pins late in each high phase
    task automatic shift(input logic [63:0] pat, input int n, output logic [63:0] dout,
                         output logic [63:0] strb, output logic [63:0] trk);
        dout = '0;
        strb = '0;
        trk  = '0;
        for (int k = 0; k < n; k++) begin
            @(negedge core_clk);
            serialIn = pat[k];
            @(negedge core_clk);
            serialClk = 1'b1;
            @(negedge core_clk);
            @(negedge core_clk);
            dout[k]   = doutPin;
            strb[k]   = strobePin;
            trk[k]    = trackInput;
            serialClk = 1'b0;
        end
    endtask
endmodule // acbd_host_model

// >>> dv/tb_top.sv
// Bench for the control-byte decoder: FIFO fill, decode table, overlapped bytes.
// Assumes the host model drives the serial pins; bench drives the FIFO side.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                core_clk = 1'b0;
    logic                reset;
    logic                resultValid;
    logic [11:0]         resultData;
    logic                selectLowN, serialClk, serialIn;
    logic                resultReady, serialOut, serialOutEn;
    logic                conversionStrobe, conversionStrobeEn, trackInput;
    logic [4:0]          posInputSel, negInputSel;
    logic                channelValid, rangeUnipolar, codingBinary;
    acbd_pkg::acbd_pwr_t powerMode;
    logic [63:0]         pat, dout, strb, trk;
    int                  errTotal = 0;
    int                  checkCount = 0;
    int                  cycleCount = 0;
    logic [11:0]         words [4] = '{12'h123, 12'habc, 12'h5a5, 12'h800};
    logic [7:0]          ctrlTab [10] = '{8'h9f, 8'hd5, 8'hae, 8'he4, 8'h9b,
                                          8'ha3, 8'hd8, 8'he1, 8'h8f, 8'hf2};
    wire logic           doutPin = serialOutEn ? serialOut : 1'bz;
    wire logic           strobePin = conversionStrobeEn ? conversionStrobe : 1'bz;

    // 25 MHz core clock
    always #20 core_clk = ~core_clk;

    acbd_decoder i_acbd_decoder (
        .core_clk(core_clk), .reset(reset), .selectLowN(selectLowN),
        .serialClk(serialClk), .serialIn(serialIn), .resultValid(resultValid),
        .resultData(resultData), .resultReady(resultReady), .serialOut(serialOut),
        .serialOutEn(serialOutEn), .conversionStrobe(conversionStrobe),
        .conversionStrobeEn(conversionStrobeEn), .trackInput(trackInput),
        .posInputSel(posInputSel), .negInputSel(negInputSel),
        .channelValid(channelValid), .rangeUnipolar(rangeUnipolar),
        .codingBinary(codingBinary), .powerMode(powerMode)
    );

    acbd_host_model i_acbd_host_model (
        .core_clk(core_clk), .selectLowN(selectLowN), .serialClk(serialClk),
        .serialIn(serialIn), .doutPin(doutPin), .strobePin(strobePin),
        .trackInput(trackInput)
    );

    // Verdict and end of run
    task automatic closeOut();
        $display("checks %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errTotal++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Hang guard
    always @(posedge core_clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 5000) begin
            errTotal++;
            closeOut();
        end
    end

    // Expected taps {pos, neg} from channel code and input type
    function automatic logic [9:0] exp_taps(input logic [2:0] ch, input logic single);
        case ({single, ch})
            4'h9: return {acbd_pkg::TAP_IN0, acbd_pkg::TAP_COM};
            4'hd: return {acbd_pkg::TAP_IN1, acbd_pkg::TAP_COM};
            4'ha: return {acbd_pkg::TAP_IN2, acbd_pkg::TAP_COM};
            4'he: return {acbd_pkg::TAP_IN3, acbd_pkg::TAP_COM};
            4'h1: return {acbd_pkg::TAP_IN0, acbd_pkg::TAP_IN1};
            4'h2: return {acbd_pkg::TAP_IN2, acbd_pkg::TAP_IN3};
            4'h5: return {acbd_pkg::TAP_IN1, acbd_pkg::TAP_IN0};
            4'h6: return {acbd_pkg::TAP_IN3, acbd_pkg::TAP_IN2};
            default: return {acbd_pkg::TAP_NONE, acbd_pkg::TAP_NONE};
        endcase
    endfunction

    // Expected power request from the two power bits
    function automatic logic [15:0] exp_pwr(input logic [1:0] p);
        if (p == 2'h0) return 16'(acbd_pkg::PWR_DOWN);
        if (p == 2'h3) return 16'(acbd_pkg::PWR_NORMAL);
        return 16'(acbd_pkg::PWR_REDUCED);
    endfunction

    // Place a control byte MSB first from rise s on
    task automatic put(input int s, input logic [7:0] c);
        for (int i = 0; i < 8; i++) pat[s+i] = c[7-i];
    endtask

    // One FIFO offer
    task automatic push(input logic [11:0] w);
        @(negedge core_clk);
        resultValid = 1'b1;
        resultData  = w;
        @(negedge core_clk);
        resultValid = 1'b0;
    endtask

    // Strobe, result, idle and tracking around a byte starting at rise s
    task automatic frame_check(input int s, input logic [11:0] w);
        logic [11:0] res;
        for (int i = 0; i < 12; i++) res[11-i] = dout[s+10+i];
        check(16'(strb[s+8 +: 3]), 16'h2);
        check(16'(res), 16'(w));
        check(16'(dout[s+22]), 16'h0);
        check(16'(trk[s+4 +: 5]), 16'he);
    endtask

    // Decoded fields of the last byte
    task automatic mux_check(input logic [7:0] c);
        logic [9:0] t;
        t = exp_taps(c[6:4], c[2]);
        check(16'({posInputSel, negInputSel}), 16'(t));
        check(16'(channelValid), 16'(t != 10'h0));
        check(16'(rangeUnipolar), 16'(c[3]));
        check(16'(codingBinary), 16'(c[2]));
        check(16'(powerMode), exp_pwr(c[1:0]));
    endtask

    // Main sequence
    initial begin
        reset       = 1'b1;
        resultValid = 1'b0;
        resultData  = 12'h000;
        repeat (20) @(negedge core_clk);
        reset = 1'b0;
        @(negedge core_clk);
        check(16'(powerMode), 16'(acbd_pkg::PWR_NORMAL));
        check(16'({conversionStrobe, trackInput, channelValid}), 16'h0);
        check(16'(resultReady), 16'h1);
        for (int i = 0; i < 4; i++) push(words[i]);
        @(negedge core_clk);
        check(16'(resultReady), 16'h0);
        push(12'hfff);
        // Leading zeros, then one byte per frame; empty FIFO yields zero
        for (int i = 0; i < 10; i++) begin
            pat = '0;
            put(3, ctrlTab[i]);
            i_acbd_host_model.set_select(1'b0);
            i_acbd_host_model.shift(pat, 26, dout, strb, trk);
            i_acbd_host_model.set_select(1'b1);
            frame_check(3, (i < 4) ? words[i] : 12'h000);
            mux_check(ctrlTab[i]);
        end
        // Select held low: sixteen zeros, byte, early stray one, byte at 16 clocks
        push(12'h9c3);
        push(12'h36a);
        pat = '0;
        put(16, 8'h9f);
        pat[31] = 1'b1;
        put(32, 8'hd5);
        i_acbd_host_model.set_select(1'b0);
        i_acbd_host_model.shift(pat, 56, dout, strb, trk);
        i_acbd_host_model.set_select(1'b1);
        frame_check(16, 12'h9c3);
        frame_check(32, 12'h36a);
        mux_check(8'hd5);
        closeOut();
    end
endmodule // tb_top

// >>> hw/acbd_decoder.sv
// Serial control-byte front end of a four-channel converter: start detect,
// field decode, multiplexer and power request, strobe and result shifter.
// Assumes the shift clock and pins are synchronous inputs to core_clk.
// Behaviour
// - An 8-bit write-only control register is loaded serially via select, data and shift clock.
// - With select low the first one sampled on the data input is the start bit; zeros before it are ignored.
// - When idle, including after power-up, the first one shifted in with select low is a start bit.
// - During a conversion a start bit is accepted only after result bit 6 has been shifted out.
// - Peak throughput is one conversion per 16 shift clocks by overlapping bytes with results.
// - Byte layout: start at bit 7, channel 6:4, range 3, input type 2, power 1:0, sent MSB first.
// - Range one gives a unipolar span to the reference, zero a bipolar span of half reference.
// - Input type zero is differential with two's complement, one is versus common with binary.
// - Power field 00 is full power-down, 01 or 10 reduced power, 11 normal operation.
// - With input type one each channel is measured against the common input in binary.
// - With input type one codes 001,101,010,110 route inputs 0,1,2,3 positive, common negative.
// - With input type zero codes 001,010,101,110 pair 0/1, 2/3, 1/0, 3/2 as positive/negative.
// - With select low one data bit is captured per rising shift clock edge, MSB first.
// - Tracking starts at the rising edge taking the type bit, hold at the falling edge after bit 0.
// - Two clocks after the last control bit the strobe pulses one clock, then 12 result bits follow.
module acbd_decoder (
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    input  wire logic                 selectLowN,
    input  wire logic                 serialClk,
    input  wire logic                 serialIn,
    input  wire logic                 resultValid,
    input  wire logic [11:0]          resultData,
    output logic                      resultReady,
    output logic                      serialOut,
    output logic                      serialOutEn,
    output logic                      conversionStrobe,
    output logic                      conversionStrobeEn,
    output logic                      trackInput,
    output logic [4:0]                posInputSel,
    output logic [4:0]                negInputSel,
    output logic                      channelValid,
    output logic                      rangeUnipolar,
    output logic                      codingBinary,
    output acbd_pkg::acbd_pwr_t       powerMode
);
    typedef enum logic {IN_IDLE, IN_SHIFT} acbd_in_t;
    typedef enum logic [1:0] {OUT_IDLE, OUT_GAP, OUT_STROBE, OUT_DATA} acbd_out_t;

    acbd_in_t    inStateQ;
    acbd_out_t   outStateQ;
    logic        sclkQ;
    logic        rise;
    logic        fall;
    logic [5:0]  shiftQ;
    logic [2:0]  bitCntQ;
    logic [7:0]  ctrlQ;
    logic [3:0]  outCntQ;
    logic [3:0]  bitIdxQ;
    logic [11:0] wordQ;
    logic        holdPendingQ;
    logic        popQ;
    logic        fifoValid;
    logic [11:0] fifoData;
    logic        armed;
    logic        startOk;
    logic        byteEnd;
    logic        convEnd;
    logic [7:0]  newByte;

    // Power field to mode
    function automatic acbd_pkg::acbd_pwr_t pwrDecode(input logic [1:0] f);
        unique case (f)
            2'h0:        pwrDecode = acbd_pkg::PWR_DOWN;
            2'h3:        pwrDecode = acbd_pkg::PWR_NORMAL;
            2'h1, 2'h2:  pwrDecode = acbd_pkg::PWR_REDUCED;
        endcase
    endfunction

    // Channel code and input type to {valid, positive taps, negative taps}
    function automatic logic [10:0] chanDecode(input logic [2:0] c, input logic single);
        chanDecode = {1'b0, acbd_pkg::TAP_NONE, acbd_pkg::TAP_NONE};
        if (single) begin
            unique case (c)
                acbd_pkg::CH_A: chanDecode = {1'b1, acbd_pkg::TAP_IN0, acbd_pkg::TAP_COM};
                acbd_pkg::CH_B: chanDecode = {1'b1, acbd_pkg::TAP_IN1, acbd_pkg::TAP_COM};
                acbd_pkg::CH_C: chanDecode = {1'b1, acbd_pkg::TAP_IN2, acbd_pkg::TAP_COM};
                acbd_pkg::CH_D: chanDecode = {1'b1, acbd_pkg::TAP_IN3, acbd_pkg::TAP_COM};
                default:        chanDecode = {1'b0, acbd_pkg::TAP_NONE, acbd_pkg::TAP_NONE};
            endcase
        end else begin
            unique case (c)
                acbd_pkg::CH_A: chanDecode = {1'b1, acbd_pkg::TAP_IN0, acbd_pkg::TAP_IN1};
                acbd_pkg::CH_C: chanDecode = {1'b1, acbd_pkg::TAP_IN2, acbd_pkg::TAP_IN3};
                acbd_pkg::CH_B: chanDecode = {1'b1, acbd_pkg::TAP_IN1, acbd_pkg::TAP_IN0};
                acbd_pkg::CH_D: chanDecode = {1'b1, acbd_pkg::TAP_IN3, acbd_pkg::TAP_IN2};
                default:        chanDecode = {1'b0, acbd_pkg::TAP_NONE, acbd_pkg::TAP_NONE};
            endcase
        end
    endfunction

    // Shift clock edges; pins are synchronous so one stage suffices
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sclkQ <= 1'b0;
        end else begin
            sclkQ <= serialClk;
        end
    end
    assign rise = serialClk && !sclkQ;
    assign fall = !serialClk && sclkQ;

    // Start qualification and byte completion
    assign armed   = (outStateQ == OUT_IDLE) ||
                     ((outStateQ == OUT_DATA) && (bitIdxQ < acbd_pkg::RESULT_ARM_BIT));
    assign startOk = (inStateQ == IN_IDLE) && !selectLowN && rise && serialIn && armed;
    assign byteEnd = (inStateQ == IN_SHIFT) && !selectLowN && rise &&
                     (bitCntQ == acbd_pkg::LAST_BIT_CNT);
    assign convEnd = (outStateQ == OUT_DATA) && rise && (bitIdxQ == 4'h0);
    assign newByte = {1'b1, shiftQ, serialIn};

    // Input shifter: start detect then seven more bits, MSB first
    always_ff @(posedge core_clk) begin
        if (reset) begin
            inStateQ <= IN_IDLE;
            shiftQ   <= '0;
            bitCntQ  <= '0;
        end else if (selectLowN) begin
            inStateQ <= IN_IDLE;
            bitCntQ  <= '0;
        end else if (startOk) begin
            inStateQ <= IN_SHIFT;
            bitCntQ  <= '0;
        end else if (byteEnd) begin
            inStateQ <= IN_IDLE;
        end else if ((inStateQ == IN_SHIFT) && rise) begin
            shiftQ  <= {shiftQ[4:0], serialIn};
            bitCntQ <= bitCntQ + 1'b1;
        end
    end

    // Write-only control register, no read path
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrlQ <= acbd_pkg::CTRL_RESET;
        end else if (byteEnd) begin
            ctrlQ <= newByte;
        end
    end

    // Multiplexer, range and coding outputs from the new byte
    always_ff @(posedge core_clk) begin
        if (reset) begin
            {channelValid, posInputSel, negInputSel} <= {1'b0, acbd_pkg::TAP_NONE,
                                                          acbd_pkg::TAP_NONE};
            rangeUnipolar <= 1'b1;
            codingBinary  <= 1'b1;
        end else if (byteEnd) begin
            {channelValid, posInputSel, negInputSel} <=
                chanDecode(newByte[acbd_pkg::CHAN_HI:acbd_pkg::CHAN_LO],
                           newByte[acbd_pkg::TYPE_BIT]);
            rangeUnipolar <= newByte[acbd_pkg::RANGE_BIT];
            codingBinary  <= newByte[acbd_pkg::TYPE_BIT];
        end
    end

    // Track from the type bit edge, hold on the falling edge after bit 0
    always_ff @(posedge core_clk) begin
        if (reset) begin
            trackInput   <= 1'b0;
            holdPendingQ <= 1'b0;
        end else if ((inStateQ == IN_SHIFT) && rise && (bitCntQ == acbd_pkg::TYPE_BIT_CNT)) begin
            trackInput <= 1'b1;
        end else if (byteEnd) begin
            holdPendingQ <= 1'b1;
        end else if (holdPendingQ && fall) begin
            trackInput   <= 1'b0;
            holdPendingQ <= 1'b0;
        end
    end

    // Conversion sequencer: gap, strobe, then twelve result bits
    always_ff @(posedge core_clk) begin
        if (reset) begin
            outStateQ        <= OUT_IDLE;
            outCntQ          <= '0;
            bitIdxQ          <= '0;
            wordQ            <= '0;
            conversionStrobe <= 1'b0;
            serialOut        <= 1'b0;
            popQ             <= 1'b0;
        end else begin
            popQ <= 1'b0;
            if (byteEnd) begin
                outStateQ <= OUT_GAP;
                outCntQ   <= '0;
            end else if (rise) begin
                unique case (outStateQ)
                    OUT_IDLE: serialOut <= 1'b0;
                    OUT_GAP: begin
                        outCntQ <= outCntQ + 1'b1;
                        if (outCntQ == acbd_pkg::STROBE_GAP - 4'h1) begin
                            outStateQ        <= OUT_STROBE;
                            conversionStrobe <= 1'b1;
                            wordQ            <= fifoValid ? fifoData : '0;
                            popQ             <= fifoValid;
                        end
                    end
                    OUT_STROBE: begin
                        conversionStrobe <= 1'b0;
                        outStateQ        <= OUT_DATA;
                        serialOut        <= wordQ[acbd_pkg::RESULT_MSB];
                        bitIdxQ          <= acbd_pkg::RESULT_MSB - 4'h1;
                    end
                    OUT_DATA: begin
                        serialOut <= wordQ[bitIdxQ];
                        if (bitIdxQ == 4'h0) begin
                            outStateQ <= OUT_IDLE;
                        end else begin
                            bitIdxQ <= bitIdxQ - 4'h1;
                        end
                    end
                endcase
            end
        end
    end

    // Pin drivers are enabled only while selected
    always_ff @(posedge core_clk) begin
        if (reset) begin
            serialOutEn        <= 1'b0;
            conversionStrobeEn <= 1'b0;
        end else begin
            serialOutEn        <= !selectLowN;
            conversionStrobeEn <= !selectLowN;
        end
    end

    // Normal power from each start bit, mode requested by the control register once a result is done
    always_ff @(posedge core_clk) begin
        if (reset) begin
            powerMode <= acbd_pkg::PWR_NORMAL;
        end else if (startOk) begin
            powerMode <= acbd_pkg::PWR_NORMAL;
        end else if (convEnd) begin
            powerMode <= pwrDecode(ctrlQ[acbd_pkg::PWR_HI:acbd_pkg::PWR_LO]);
        end
    end

    // Result words queue ahead of the shifter
    acbd_fifo #(
        .WIDTH (acbd_pkg::RESULT_W),
        .DEPTH (acbd_pkg::FIFO_DEPTH)
    ) resultFifo (
        .core_clk (core_clk),
        .reset    (reset),
        .inValid  (resultValid),
        .inData   (resultData),
        .inReady  (resultReady),
        .outValid (fifoValid),
        .outData  (fifoData),
        .outReady (popQ)
    );

    // Checks
    sequence startSeen_s;
        (inStateQ == IN_IDLE) && !selectLowN && rise && serialIn && (outStateQ == OUT_IDLE);
    endsequence
    sequence lastBit_s;
        byteEnd;
    endsequence

    start_idle_a: assert property (@(posedge core_clk) disable iff (reset)
        startSeen_s |=> (inStateQ == IN_SHIFT) && (bitCntQ == 3'h0))
        else $error("start bit not taken while idle");

    zeros_ignored_a: assert property (@(posedge core_clk) disable iff (reset)
        (inStateQ == IN_IDLE) && rise && !serialIn |=> (inStateQ == IN_IDLE))
        else $error("zero taken as start bit");

    overlap_block_a: assert property (@(posedge core_clk) disable iff (reset)
        (inStateQ == IN_IDLE) && (outStateQ == OUT_DATA) && (bitIdxQ >= acbd_pkg::RESULT_ARM_BIT)
        && !(convEnd) |=> (inStateQ == IN_IDLE))
        else $error("start accepted before result bit 6");

    track_begin_a: assert property (@(posedge core_clk) disable iff (reset)
        (inStateQ == IN_SHIFT) && rise && (bitCntQ == acbd_pkg::TYPE_BIT_CNT) |=> trackInput [*2])
        else $error("tracking did not start at type bit");

    hold_after_a: assert property (@(posedge core_clk) disable iff (reset)
        holdPendingQ && fall |=> !trackInput && !holdPendingQ)
        else $error("hold not entered after last bit");

    strobe_gap_a: assert property (@(posedge core_clk) disable iff (reset)
        lastBit_s ##1 (!rise) [*1] |-> (outStateQ == OUT_GAP) && !conversionStrobe)
        else $error("strobe too early after control byte");

    strobe_one_a: assert property (@(posedge core_clk) disable iff (reset)
        $rose(conversionStrobe) |-> $past(outStateQ) == OUT_GAP && outStateQ == OUT_STROBE)
        else $error("strobe not following gap");

    data_end_a: assert property (@(posedge core_clk) disable iff (reset)
        convEnd && !byteEnd |=> (outStateQ == OUT_IDLE) && (serialOut == $past(wordQ[0])))
        else $error("result did not end after bit 0");

    pwr_apply_a: assert property (@(posedge core_clk) disable iff (reset)
        convEnd && !startOk |=> powerMode == pwrDecode(ctrlQ[1:0]))
        else $error("power mode not applied after conversion");

    chan_invalid_a: assert property (@(posedge core_clk) disable iff (reset)
        !channelValid |-> (posInputSel == 5'h00) && (negInputSel == 5'h00))
        else $error("invalid channel code drives a tap");

    single_common_a: assert property (@(posedge core_clk) disable iff (reset)
        channelValid && codingBinary |-> negInputSel == 5'h10)
        else $error("single-ended without common on negative side");
endmodule // acbd_decoder

// >>> hw/acbd_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
module acbd_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    output logic                  outValid,
    output logic      [WIDTH-1:0] outData,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] memQ [DEPTH];
    logic [AW-1:0]    wrPtrQ;
    logic [AW-1:0]    rdPtrQ;
    logic [AW:0]      countQ;
    logic             push;
    logic             pop;
    logic [AW:0]      countD;

    // Handshakes on each side
    assign push = inValid && inReady;
    assign pop  = outValid && outReady;
    assign outData = memQ[rdPtrQ];

    // Occupancy next value
    always_comb begin
        countD = countQ;
        if (push && !pop) begin
            countD = countQ + 1'b1;
        end else if (pop && !push) begin
            countD = countQ - 1'b1;
        end
    end

    // Storage
    always_ff @(posedge core_clk) begin
        if (push) begin
            memQ[wrPtrQ] <= inData;
        end
    end

    // Pointers, count and registered flags
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wrPtrQ   <= '0;
            rdPtrQ   <= '0;
            countQ   <= '0;
            inReady  <= 1'b1;
            outValid <= 1'b0;
        end else begin
            if (push) begin
                wrPtrQ <= (wrPtrQ == AW'(DEPTH - 1)) ? '0 : wrPtrQ + 1'b1;
            end
            if (pop) begin
                rdPtrQ <= (rdPtrQ == AW'(DEPTH - 1)) ? '0 : rdPtrQ + 1'b1;
            end
            countQ   <= countD;
            inReady  <= (countD != (AW + 1)'(DEPTH));
            outValid <= (countD != '0);
        end
    end
endmodule // acbd_fifo

// >>> hw/acbd_pkg.sv
// Constants and types shared by the control-byte decoder and its result FIFO.
// Assumes a single core clock; all serial pins are sampled synchronously.
package acbd_pkg;
    // Control byte layout
    localparam int CTRL_W        = 8;
    localparam int START_BIT     = 7;
    localparam int CHAN_HI       = 6;
    localparam int CHAN_LO       = 4;
    localparam int RANGE_BIT     = 3;
    localparam int TYPE_BIT      = 2;
    localparam int PWR_HI        = 1;
    localparam int PWR_LO        = 0;
    localparam logic [7:0] CTRL_RESET = 8'h03;

    // Shift counting: bits after the start bit, index of the type bit
    localparam logic [2:0] LAST_BIT_CNT = 3'h6;
    localparam logic [2:0] TYPE_BIT_CNT = 3'h4;

    // Result word and overlap point
    localparam int RESULT_W = 12;
    localparam logic [3:0] RESULT_MSB     = 4'hb;
    localparam logic [3:0] RESULT_ARM_BIT = 4'h6;
    localparam int FIFO_DEPTH = 4;

    // Shift clocks from last control bit to the strobe
    localparam logic [3:0] STROBE_GAP = 4'h2;

    // Channel codes
    localparam logic [2:0] CH_A = 3'h1;
    localparam logic [2:0] CH_B = 3'h5;
    localparam logic [2:0] CH_C = 3'h2;
    localparam logic [2:0] CH_D = 3'h6;

    // One-hot multiplexer taps: input_0..input_3, common_input
    localparam logic [4:0] TAP_NONE = 5'h00;
    localparam logic [4:0] TAP_IN0  = 5'h01;
    localparam logic [4:0] TAP_IN1  = 5'h02;
    localparam logic [4:0] TAP_IN2  = 5'h04;
    localparam logic [4:0] TAP_IN3  = 5'h08;
    localparam logic [4:0] TAP_COM  = 5'h10;

    typedef enum logic [1:0] {PWR_DOWN, PWR_REDUCED, PWR_NORMAL} acbd_pwr_t;
endpackage
